// ### rtl/dfc_map.svh
// register offsets, field positions, reset values and timing counts of the feature block
`ifndef DFC_MAP_SVH
`define DFC_MAP_SVH

// ==========================================================
// register offsets (byte index on the serial control bus)
`define DFC_OFS_GENERAL_CONFIG 8'h00
`define DFC_OFS_FEATURES_TWO   8'h03
`define DFC_OFS_REPEAT_CONFIG  8'h04

// ==========================================================
// field positions
`define DFC_BIT_REG_SELECT     0
`define DFC_LSB_CFG_FIELD      2
`define DFC_BIT_STROBE_EDGE    4
`define DFC_BIT_EQ_ON          4
`define DFC_LSB_SPREAD         0
`define DFC_BIT_REPEAT_EN      7

// ==========================================================
// strap pin positions on the parallel output bus
`define DFC_PIN_CFILT          23
`define DFC_PIN_EQ_LSB         12
`define DFC_PIN_SPREAD_LSB     3

// ==========================================================
// reset values
`define DFC_RST_GENERAL        8'h00
`define DFC_RST_FEATURES_TWO   8'h00
`define DFC_RST_REPEAT         8'h00

// ==========================================================
// modulation dividers, normal and low-frequency tables
// clock divided by 2168, 1300, 868, 650 and by 620, 370, 258, 192
`define DFC_DIV_N0             12'h878
`define DFC_DIV_N1             12'h514
`define DFC_DIV_N2             12'h364
`define DFC_DIV_N3             12'h28A
`define DFC_DIV_L0             12'h26C
`define DFC_DIV_L1             12'h172
`define DFC_DIV_L2             12'h102
`define DFC_DIV_L3             12'h0C0

`endif

// ### rtl/dfc_pkg.sv
// types shared by the feature configuration block
package dfc_pkg;

	// ==========================================================
	// two-bit configuration field codes
	typedef enum logic [1:0] {
		DFC_CFG_FILTER_OFF = 2'b00,
		DFC_CFG_FILTER_ON  = 2'b01,
		DFC_CFG_RSVD_2     = 2'b10,
		DFC_CFG_RSVD_3     = 2'b11
	} dfc_cfg_t;

	// spread deviation steps, 0.5 % each
	typedef enum logic [1:0] {
		DFC_DEV_0P5 = 2'b00,
		DFC_DEV_1P0 = 2'b01,
		DFC_DEV_1P5 = 2'b10,
		DFC_DEV_2P0 = 2'b11
	} dfc_dev_t;

endpackage : dfc_pkg

// ### rtl/dfc_spread.sv
// spread profile decoder and modulation rate timer
`timescale 1ns/1ps
`include "dfc_map.svh"

module dfc_spread (
	// clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             reset_in,
	// profile selection
	input  wire logic [3:0]       spread_profile_select_in,
	input  wire logic             low_frequency_select_in,
	// decoded profile
	output logic                  spread_on_out,
	output dfc_pkg::dfc_dev_t     spread_dev_out,
	output logic [11:0]           spread_div_out,
	output logic                  spread_tick_out
);

	// ==========================================================
	// divider lookup by rate group and table
	function automatic logic [11:0] dfc_div(input logic [1:0] grp, input logic lf);
		logic [11:0] d;
		d = `DFC_DIV_N0;
		case ({lf, grp})
			3'b000:  d = `DFC_DIV_N0;
			3'b001:  d = `DFC_DIV_N1;
			3'b010:  d = `DFC_DIV_N2;
			3'b011:  d = `DFC_DIV_N3;
			3'b100:  d = `DFC_DIV_L0;
			3'b101:  d = `DFC_DIV_L1;
			3'b110:  d = `DFC_DIV_L2;
			default: d = `DFC_DIV_L3;
		endcase
		return d;
	endfunction : dfc_div

	logic [3:0]        code_m1;   // profile code less one
	logic              on_d;      // spreading active
	dfc_pkg::dfc_dev_t dev_d;     // deviation step
	logic [11:0]       div_d;     // modulation divider
	logic [11:0]       cnt_q;     // modulation period counter
	logic [11:0]       cnt_d;
	logic              tick_d;    // one pulse per modulation period

	// ==========================================================
	// decode and period count
	always_comb begin
		code_m1 = spread_profile_select_in - 4'h1;
		on_d    = (spread_profile_select_in != 4'h0);
		dev_d   = dfc_pkg::dfc_dev_t'(code_m1[1:0]);
		div_d   = dfc_div(code_m1[3:2], low_frequency_select_in);
		cnt_d   = 12'h000;
		tick_d  = 1'b0;
		if (on_d) begin
			if (cnt_q >= div_d - 12'h001) begin
				tick_d = 1'b1;      // period done
			end else begin
				cnt_d = cnt_q + 12'h001;
			end
		end
	end

	// registers
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_q           <= 12'h000;
			spread_on_out   <= 1'b0;
			spread_dev_out  <= dfc_pkg::DFC_DEV_0P5;
			spread_div_out  <= `DFC_DIV_N0;
			spread_tick_out <= 1'b0;
		end else begin
			cnt_q           <= cnt_d;
			spread_on_out   <= on_d;
			spread_dev_out  <= dev_d;
			spread_div_out  <= div_d;
			spread_tick_out <= tick_d;
		end
	end

endmodule : dfc_spread

// ### rtl/dfc_top.sv
// deserializer feature configuration: registers, straps and output data path
`timescale 1ns/1ps
`include "dfc_map.svh"

module dfc_top (
	// clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	// register port behind the serial control bus
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	output logic [7:0]       reg_rdata_out,
	output logic             reg_rvalid_out,
	// control pins
	input  wire logic        power_down_n_in,
	input  wire logic        strobe_edge_select_in,
	input  wire logic        low_frequency_select_in,
	// recovered link payload
	input  wire logic [23:0] link_data_in,
	input  wire logic [2:0]  control_bits_in,
	// parallel output pins, also strap inputs
	input  wire logic [23:0] parallel_out_pins_in,
	output logic [23:0]      parallel_out_pins_out,
	output logic             parallel_out_pins_oe_out,
	output logic [2:0]       control_bits_out,
	// feature controls
	output logic             equalizer_on_out,
	output logic [3:0]       equalizer_strap_code_out,
	output logic             control_filter_on_out,
	output logic             strobe_rising_out,
	output logic             repeat_serial_output_en_out,
	output logic             spread_on_out,
	output dfc_pkg::dfc_dev_t spread_dev_out,
	output logic [11:0]      spread_div_out,
	output logic             spread_tick_out
);

	// ==========================================================
	// register and strap state
	// every byte keeps all eight written bits, reserved ones too, so a
	// host reads back exactly what it wrote; reserved bits drive nothing
	// strap copies are taken once per power-down release, then held
	logic [7:0] general_q,  general_d;   // strobe edge, config field, register select
	logic [7:0] feat_two_q, feat_two_d;  // receiver_features_two
	logic [7:0] repeat_q,   repeat_d;    // repeat_output_config
	logic [7:0] rdata_d;                 // read byte, zero unless a read
	logic       rvalid_d;                // read answer pulse
	// power-down edge detector
	logic       pdn_q;                   // previous power-down level
	logic       release_w;               // power-down release seen
	logic       oe_d;                    // drive pins, one cycle after release
	logic       strap_cfilt_q, strap_cfilt_d;  // control filter strap, pin 23
	logic [3:0] strap_eq_q,    strap_eq_d;     // equalizer code, pins 15 to 12
	logic [3:0] strap_ssc_q,   strap_ssc_d;    // spread code, pins 6 to 3

	// ==========================================================
	// register writes, reads and strap capture
	// one write and one read can be taken per edge; a read in the cycle of a
	// write to the same byte still returns the old value
	always_comb begin
		// defaults: hold every byte, no read data
		general_d  = general_q;
		feat_two_d = feat_two_q;
		repeat_d   = repeat_q;
		rdata_d    = 8'h00;
		rvalid_d   = reg_read_in;   // every read is answered, mapped or not
		// whole bytes stored, reserved bits included
		if (reg_write_in) begin
			// bytes outside the map leave all state as it was
			case (reg_addr_in)
				`DFC_OFS_GENERAL_CONFIG: general_d  = reg_wdata_in;
				`DFC_OFS_FEATURES_TWO:   feat_two_d = reg_wdata_in;
				`DFC_OFS_REPEAT_CONFIG:  repeat_d   = reg_wdata_in;
				default:                 general_d  = general_q;     // unmapped ignored
			endcase
		end
		// reserved bits read back as written
		// a read of an unmapped byte answers with zero
		if (reg_read_in) begin
			case (reg_addr_in)
				`DFC_OFS_GENERAL_CONFIG: rdata_d = general_q;
				`DFC_OFS_FEATURES_TWO:   rdata_d = feat_two_q;
				`DFC_OFS_REPEAT_CONFIG:  rdata_d = repeat_q;
				default:                 rdata_d = 8'h00;
			endcase
		end
		// straps caught at the power-down release, then held; pdn_q resets
		// low, so a pin already high after reset counts as a release
		release_w     = power_down_n_in & ~pdn_q;
		// pins stay undriven in the release cycle so the straps are read
		// from resistors, not from our own output data
		oe_d          = power_down_n_in & pdn_q;
		strap_cfilt_d = strap_cfilt_q;
		strap_eq_d    = strap_eq_q;
		strap_ssc_d   = strap_ssc_q;
		// one snapshot of all three straps in the same cycle
		if (release_w) begin
			strap_cfilt_d = parallel_out_pins_in[`DFC_PIN_CFILT];
			strap_eq_d    = parallel_out_pins_in[`DFC_PIN_EQ_LSB +: 4];
			strap_ssc_d   = parallel_out_pins_in[`DFC_PIN_SPREAD_LSB +: 4];
		end
	end

	// register bytes, read answer and strap copies
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin                           // power-on values
			general_q      <= `DFC_RST_GENERAL;
			feat_two_q     <= `DFC_RST_FEATURES_TWO;
			repeat_q       <= `DFC_RST_REPEAT;
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
			pdn_q          <= 1'b0;
			strap_cfilt_q  <= 1'b0;
			strap_eq_q     <= 4'h0;
			strap_ssc_q    <= 4'h0;
		end else begin
			general_q      <= general_d;
			feat_two_q     <= feat_two_d;
			repeat_q       <= repeat_d;
			reg_rdata_out  <= rdata_d;
			reg_rvalid_out <= rvalid_d;
			// sample the pin for the release detector
			pdn_q          <= power_down_n_in;
			strap_cfilt_q  <= strap_cfilt_d;
			strap_eq_q     <= strap_eq_d;
			strap_ssc_q    <= strap_ssc_d;
		end
	end

	// ==========================================================
	// feature source selection
	// a change of the select bit reaches the outputs one cycle later;
	// the equalizer gain bits 7 to 5 are stored but steer nothing here
	logic              reg_mode_w;   // registers rule over straps
	dfc_pkg::dfc_cfg_t cfg_w;        // configuration field
	logic              eq_on_d;      // equalizer enable
	logic              cfilt_d;      // control signal filter enable
	logic              strobe_d;     // 1: rising-edge strobing
	logic              rep_en_d;     // repeat serial output enable
	logic [3:0]        ssc_sel_w;    // chosen spread profile code

	// pick registers or straps, one whole set at a time
	always_comb begin
		reg_mode_w = general_q[`DFC_BIT_REG_SELECT];
		cfg_w      = dfc_pkg::dfc_cfg_t'(general_q[`DFC_LSB_CFG_FIELD +: 2]);
		rep_en_d   = repeat_q[`DFC_BIT_REPEAT_EN];   // register in both modes
		if (reg_mode_w) begin
			// register mode: equalizer, filter, strobe edge and spread code from the bytes
			eq_on_d   = feat_two_q[`DFC_BIT_EQ_ON];
			// reserved codes 10 and 11 leave the filter off
			cfilt_d   = (cfg_w == dfc_pkg::DFC_CFG_FILTER_ON);
			strobe_d  = general_q[`DFC_BIT_STROBE_EDGE];
			ssc_sel_w = feat_two_q[`DFC_LSB_SPREAD +: 4];
		end else begin
			// strap mode: captured straps and the strobe pin;
			// any nonzero equalizer code turns the equalizer on
			eq_on_d   = (strap_eq_q != 4'h0);
			cfilt_d   = strap_cfilt_q;
			strobe_d  = strobe_edge_select_in;
			ssc_sel_w = strap_ssc_q;
		end
	end

	// ==========================================================
	// payload and feature output registers
	// the payload passes through a single register stage with no buffer,
	// so pins follow the link one cycle late; every output here is a flop
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			// pins undriven and features off while in reset
			parallel_out_pins_out       <= 24'h00_0000;
			parallel_out_pins_oe_out    <= 1'b0;
			control_bits_out            <= 3'h0;
			equalizer_on_out            <= 1'b0;
			equalizer_strap_code_out    <= 4'h0;
			control_filter_on_out       <= 1'b0;
			strobe_rising_out           <= 1'b0;
			repeat_serial_output_en_out <= 1'b0;
		end else begin
			parallel_out_pins_out       <= link_data_in;
			parallel_out_pins_oe_out    <= oe_d;                     // straps readable first
			control_bits_out            <= control_bits_in;
			// feature levels, one cycle after the source picks them
			equalizer_on_out            <= eq_on_d;
			equalizer_strap_code_out    <= strap_eq_q;
			control_filter_on_out       <= cfilt_d;
			strobe_rising_out           <= strobe_d;
			repeat_serial_output_en_out <= rep_en_d;
		end
	end

	// ==========================================================
	// spread profile decoder
	// the low-frequency select is a pin in both modes; the decoder registers
	// its own outputs, so spread outputs trail the code by one cycle
	dfc_spread u_spread (
		.core_clk_in              (core_clk_in),
		.reset_in                 (reset_in),
		.spread_profile_select_in (ssc_sel_w),
		.low_frequency_select_in  (low_frequency_select_in),
		.spread_on_out            (spread_on_out),
		.spread_dev_out           (spread_dev_out),
		.spread_div_out           (spread_div_out),
		.spread_tick_out          (spread_tick_out)
	);

endmodule : dfc_top

// ### bench/dfc_strap_pins.sv
// pin-level model of the strap resistors on the parallel output bus
`timescale 1ns/1ps

module dfc_strap_pins #(
	parameter logic [23:0] STRAP_UP = 24'h80_9010 // pull-ups on bits 23, 15, 12, 4
) (
	// ==========================================================
	// device side of the shared pins
	input  wire logic        drive_oe_in,
	input  wire logic [23:0] drive_in,
	// resolved pin levels
	output logic      [23:0] pins_out
);
	// unstrapped pins carry weak pull-downs; device drive wins when enabled
	assign pins_out = drive_oe_in ? drive_in : STRAP_UP;
endmodule : dfc_strap_pins

// ### bench/dfc_top_sva.sv
// concurrent checks on the ports of the feature block
`timescale 1ns/1ps

module dfc_top_sva (
	// clock, reset, register port
	input wire logic        core_clk_in,
	input wire logic        reset_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic        reg_write_in,
	input wire logic        reg_read_in,
	input wire logic        reg_rvalid_out,
	// pins and payload
	input wire logic        power_down_n_in,
	input wire logic [23:0] link_data_in,
	input wire logic [2:0]  control_bits_in,
	input wire logic [23:0] parallel_out_pins_in,
	input wire logic [23:0] parallel_out_pins_out,
	input wire logic        parallel_out_pins_oe_out,
	input wire logic [2:0]  control_bits_out,
	// feature outputs
	input wire logic [3:0]  equalizer_strap_code_out,
	input wire logic        repeat_serial_output_en_out,
	input wire logic        spread_on_out,
	input wire logic [11:0] spread_div_out,
	input wire logic        spread_tick_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	logic [11:0] gap_q;    // cycles since last tick
	logic        gap_ok_q; // tick seen, divider unchanged since
	logic [11:0] div_q;    // divider one cycle ago
	// ==========================================================
	// tick spacing helper
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			gap_q <= 12'h001;
			gap_ok_q <= 1'b0;
			div_q <= 12'h000;
		end else begin
			div_q <= spread_div_out;
			gap_q <= spread_tick_out ? 12'h001 : gap_q + 12'h001;
			gap_ok_q <= (spread_tick_out | gap_ok_q) & spread_on_out & (spread_div_out == div_q);
		end
	end
	// ==========================================================
	// assertions
	a_rvalid_after_read: assert property (reg_read_in |=> reg_rvalid_out)
		else $error("no read answer one cycle after read strobe");
	a_rvalid_only_read: assert property (reg_rvalid_out |-> $past(reg_read_in))
		else $error("read answer without read strobe");
	a_repeat_bit_seven: assert property ((reg_write_in && reg_addr_in == 8'h04) ##1
		!(reg_write_in && reg_addr_in == 8'h04) |=>
		repeat_serial_output_en_out == $past(reg_wdata_in[7], 2))
		else $error("repeat output enable does not follow bit 7");
	a_payload_copy: assert property (1 |=> parallel_out_pins_out == $past(link_data_in)
		&& control_bits_out == $past(control_bits_in))
		else $error("payload not copied with one cycle latency");
	a_oe_needs_power: assert property (parallel_out_pins_oe_out |-> $past(power_down_n_in))
		else $error("pins driven during power-down");
	a_strap_capture: assert property (power_down_n_in && !$past(power_down_n_in) |-> ##2
		equalizer_strap_code_out == $past(parallel_out_pins_in[15:12], 2))
		else $error("strap code not captured at release");
	a_strap_held: assert property (!power_down_n_in && !$past(power_down_n_in) |=>
		$stable(equalizer_strap_code_out))
		else $error("strap code moved in power-down");
	a_spread_off_quiet: assert property (!spread_on_out [*3] |-> !spread_tick_out)
		else $error("tick while spreading off");
	a_tick_spacing: assert property (spread_tick_out && gap_ok_q && spread_div_out == div_q
		|-> gap_q == spread_div_out)
		else $error("tick spacing differs from divider");
	c_tick: cover property (spread_tick_out);
	c_read: cover property (reg_rvalid_out);
	c_release: cover property (power_down_n_in && !$past(power_down_n_in));
endmodule : dfc_top_sva

bind dfc_top dfc_top_sva u_dfc_top_sva (.core_clk_in(core_clk_in), .reset_in(reset_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
	.reg_read_in(reg_read_in), .reg_rvalid_out(reg_rvalid_out),
	.power_down_n_in(power_down_n_in), .link_data_in(link_data_in),
	.control_bits_in(control_bits_in), .parallel_out_pins_in(parallel_out_pins_in),
	.parallel_out_pins_out(parallel_out_pins_out),
	.parallel_out_pins_oe_out(parallel_out_pins_oe_out), .control_bits_out(control_bits_out),
	.equalizer_strap_code_out(equalizer_strap_code_out),
	.repeat_serial_output_en_out(repeat_serial_output_en_out), .spread_on_out(spread_on_out),
	.spread_div_out(spread_div_out), .spread_tick_out(spread_tick_out));

// ### bench/tb_top.sv
// self-checking bench for the feature configuration block
`timescale 1ns/1ps
`include "dfc_map.svh"

module tb_top;
	logic core_clk_in, reset_in, wr_en, rd_en, pdn_n, strobe_sel, lf_sel, rvalid;
	logic [7:0] addr, wdata, rdata;
	logic [23:0] link, pins_in, pins_out;
	logic [2:0] ctl, ctl_out;
	logic oe, eq_on, cfilt, strobe_rise, rep_en, sp_on, tick;
	logic [3:0] eq_code;
	logic [11:0] div;
	dfc_pkg::dfc_dev_t dev;
	logic [11:0] tab [8];
	int err_count, comparisons, ticks;
	dfc_top u_dfc_top (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .power_down_n_in(pdn_n), .strobe_edge_select_in(strobe_sel),
		.low_frequency_select_in(lf_sel), .link_data_in(link), .control_bits_in(ctl),
		.parallel_out_pins_in(pins_in), .parallel_out_pins_out(pins_out),
		.parallel_out_pins_oe_out(oe), .control_bits_out(ctl_out), .equalizer_on_out(eq_on),
		.equalizer_strap_code_out(eq_code), .control_filter_on_out(cfilt),
		.strobe_rising_out(strobe_rise), .repeat_serial_output_en_out(rep_en),
		.spread_on_out(sp_on), .spread_dev_out(dev), .spread_div_out(div), .spread_tick_out(tick));
	dfc_strap_pins u_dfc_strap_pins (.drive_oe_in(oe), .drive_in(pins_out), .pins_out(pins_in));
	// ==========================================================
	// compare, register access, verdict
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge core_clk_in);
		wr_en <= 1'b0;
		repeat (2) @(posedge core_clk_in); // feature outputs settle
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk_in);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk_in);
		rd_en <= 1'b0;
		#1;
		check(rvalid, 1'b1);
		check(rdata, exp);
	endtask : rd
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	// ==========================================================
	// clock and watchdog
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	initial begin
		#40_000;
		err_count++;
		print_verdict();
	end
	// ==========================================================
	// test sequence
	initial begin
		tab = '{`DFC_DIV_N0, `DFC_DIV_N1, `DFC_DIV_N2, `DFC_DIV_N3,
			`DFC_DIV_L0, `DFC_DIV_L1, `DFC_DIV_L2, `DFC_DIV_L3};
		{reset_in, wr_en, rd_en, pdn_n, strobe_sel, lf_sel} = 6'b10_0000;
		{addr, wdata, link, ctl} = '0;
		repeat (5) @(posedge core_clk_in);
		reset_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		pdn_n <= 1'b1; // release: straps sampled
		repeat (3) @(posedge core_clk_in);
		#1;
		check(eq_code, 4'b1001);
		check(eq_on, 1'b1);
		check(cfilt, 1'b1);
		check(strobe_rise, 1'b0);
		check({sp_on, dev, div}, {1'b1, dfc_pkg::DFC_DEV_1P0, `DFC_DIV_N0});
		check(rep_en, 1'b0);
		$display("test straps done");
		rd(8'h00, 8'h00);
		rd(8'h03, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h07, 8'h00);
		wr(8'h04, 8'hFF);
		check(rep_en, 1'b1);
		rd(8'h04, 8'hFF);
		wr(8'h04, 8'h7F);
		check(rep_en, 1'b0);
		$display("test repeat done");
		wr(8'h00, 8'h05);
		check({cfilt, eq_on}, 2'b10);
		wr(8'h00, 8'h09);
		check(cfilt, 1'b0);
		wr(8'h00, 8'h11);
		check({cfilt, strobe_rise}, 2'b01);
		wr(8'h03, 8'h10);
		check(eq_on, 1'b1);
		wr(8'h03, 8'hE0);
		check(eq_on, 1'b0);
		$display("test register mode done");
		for (int lf = 0; lf < 2; lf++) begin
			for (int c = 0; c < 16; c++) begin
				@(posedge core_clk_in);
				lf_sel <= lf[0];
				wr(8'h03, c[7:0]);
				check(sp_on, c != 0);
				if (c != 0) check({dev, div}, {2'(c - 1), tab[{lf[0], 2'(c - 1 >> 2)}]});
			end
		end
		ticks = 0;
		repeat (576) begin
			@(posedge core_clk_in);
			#1;
			ticks += tick;
		end
		check(24'(ticks), 24'h00_0003);
		$display("test spread done");
		wr(8'h00, 8'h00);
		@(posedge core_clk_in);
		link <= 24'hA5_5A3C;
		ctl <= 3'b101;
		strobe_sel <= 1'b1;
		@(posedge core_clk_in);
		#1;
		check({pins_out, ctl_out, oe}, {24'hA5_5A3C, 3'b101, 1'b1});
		check(strobe_rise, 1'b1);
		check({eq_code, eq_on}, {4'b1001, 1'b1});
		$display("test payload done");
		print_verdict();
	end
endmodule : tb_top
